// ### rtl/bsad_cfg.svh
// Constants for the searchlight aspect driver: offsets, codes, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef BSAD_CFG_SVH
`define BSAD_CFG_SVH
// ==========================================
// Register byte offsets
`define BSAD_OFF_TABLE 8'h00
`define BSAD_OFF_CMD 8'h20
`define BSAD_OFF_BRIGHT 8'h24
`define BSAD_OFF_STATUS 8'h28
`define BSAD_TABLE_TOP 3'h0
// ==========================================
// Field widths and reset values
`define BSAD_ASP_W 15
`define BSAD_DUTY_RST 8'h80
`define BSAD_WORD_ZERO 32'h0000_0000
// ==========================================
// Lamp entry codes
`define BSAD_LAMP_NONE 3'h0
`define BSAD_LAMP_FIRST 3'h1
`define BSAD_LAMP_SECOND 3'h2
`define BSAD_LAMP_THIRD 3'h3
`define BSAD_LAMP_FOURTH 3'h4
// ==========================================
// Timing
`define BSAD_FLICKER_MS 100
`define BSAD_CLK_KHZ 50000
`endif

// ### rtl/bsad_pkg.sv
// Types shared by the searchlight aspect driver.
// Assumes bsad_cfg.svh supplies the widths.
`include "bsad_cfg.svh"
package bsad_pkg;
  // ==========================================
  // One aspect table entry, low bit first is lamp_a
  typedef struct packed {
    logic prelight_effect;
    logic pair_reversal_cd;
    logic pair_reversal_ab;
    logic [2:0] lamp_d;
    logic [2:0] lamp_c;
    logic [2:0] lamp_b;
    logic [2:0] lamp_a;
  } bsad_aspect_type;

  // ==========================================
  // Display sequencer states
  typedef enum logic [2:0] {
    BSAD_DARK = 3'b001,
    BSAD_PRE = 3'b010,
    BSAD_SHOW = 3'b100
  } bsad_state_type;

  // ==========================================
  // Whole module state
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    bsad_aspect_type [7:0] table_q;
    logic [7:0] stage_red;
    logic [7:0] stage_green;
    logic [7:0] duty_red;
    logic [7:0] duty_green;
    logic [2:0] aspect;
    bsad_state_type st;
    logic [22:0] tmr;
    logic [8:0] pwm;
    logic strap_done;
    logic common_anode;
    logic [3:0] drive;
  } bsad_regs_type;
endpackage : bsad_pkg

// ### rtl/bsad_top.sv
// Bi-polar searchlight aspect driver with an APB register slave.
// Assumes a synchronous APB master on pclk and a static polarity jumper.
//
// Design decisions made here: the register addresses and the APB slave port.
`include "bsad_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// One lamp entry code to a one-hot output mask, empty for none and unused codes
module bsad_lamp_decode
  import bsad_pkg::*;
(
  input wire logic [2:0] code,
  output logic [3:0] mask
);
  always_comb begin
    case (code)
      `BSAD_LAMP_FIRST: mask = 4'h1;
      `BSAD_LAMP_SECOND: mask = 4'h2;
      `BSAD_LAMP_THIRD: mask = 4'h4;
      `BSAD_LAMP_FOURTH: mask = 4'h8;
      default: mask = 4'h0;
    endcase
  end
endmodule : bsad_lamp_decode

module bsad_top
  import bsad_pkg::*;
#(
  parameter int FLICKER_CYCLES = `BSAD_FLICKER_MS * `BSAD_CLK_KHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic common_anode_select,
  output logic head_out_first,
  output logic head_out_second,
  output logic head_out_third,
  output logic head_out_fourth
);

  bsad_regs_type s;
  bsad_regs_type next_s;

  logic access;
  logic wr;
  logic in_table;
  logic cmd_hit;
  logic [2:0] cmd_aspect;
  bsad_aspect_type cur;
  logic [8:0] pwm_sum;
  logic [8:0] pwm_inc;
  logic red_phase;
  logic [3:0] ma;
  logic [3:0] mb;
  logic [3:0] mc;
  logic [3:0] md;
  logic [3:0] lit;

  // ==========================================
  // Bus decode
  assign access = psel & penable;
  assign wr = access & s.pready & pwrite;
  assign in_table = paddr[7:5] == `BSAD_TABLE_TOP;
  assign cmd_hit = wr & (paddr == `BSAD_OFF_CMD);
  // Line index in [1:0], closed in [2]; first line thrown is aspect one
  assign cmd_aspect = {pwdata[1], pwdata[2], pwdata[0]};

  // ==========================================
  // Lamp mask of the aspect on show
  assign cur = s.table_q[s.aspect];
  assign pwm_sum = {1'b0, s.duty_red} + {1'b0, s.duty_green};
  assign pwm_inc = s.pwm + 9'h001;
  // Red share of each period first, then green
  assign red_phase = s.pwm < {1'b0, s.duty_red};
  bsad_lamp_decode bsad_lamp_decode_a_i (
    .code(cur.lamp_a),
    .mask(ma)
  );
  bsad_lamp_decode bsad_lamp_decode_b_i (
    .code(cur.lamp_b),
    .mask(mb)
  );
  bsad_lamp_decode bsad_lamp_decode_c_i (
    .code(cur.lamp_c),
    .mask(mc)
  );
  bsad_lamp_decode bsad_lamp_decode_d_i (
    .code(cur.lamp_d),
    .mask(md)
  );

  always_comb begin
    lit = 4'h0;
    case (s.st)
      BSAD_PRE: begin
        lit = mb;
      end
      BSAD_SHOW: begin
        // Both ends of a pair high would leave the die dark, so a flagged
        // pair shows only one entry at a time
        if (cur.pair_reversal_ab) begin
          lit = red_phase ? ma : mb;
        end else if (!cur.prelight_effect) begin
          lit = ma | mb;
        end else begin
          lit = ma;
        end
        if (cur.pair_reversal_cd) begin
          lit = lit | (red_phase ? mc : md);
        end else begin
          lit = lit | mc | md;
        end
      end
      default: begin
        lit = 4'h0;
      end
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.pready = access & ~s.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata = `BSAD_WORD_ZERO;
    if (access & ~s.pready & ~pwrite) begin
      if (in_table) begin
        next_s.prdata = {17'h0_0000, s.table_q[paddr[4:2]]};
      end else if (paddr == `BSAD_OFF_CMD) begin
        next_s.prdata = {29'h0000_0000, s.aspect};
      end else if (paddr == `BSAD_OFF_BRIGHT) begin
        next_s.prdata = {s.duty_green, s.duty_red, s.stage_green, s.stage_red};
      end else if (paddr == `BSAD_OFF_STATUS) begin
        next_s.prdata = {21'h00_0000, s.drive, s.common_anode, s.st, s.aspect};
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (access & ~s.pready & pwrite) begin
      if (!in_table && paddr != `BSAD_OFF_CMD && paddr != `BSAD_OFF_BRIGHT) begin
        next_s.pslverr = 1'b1;
      end
    end
    if (wr & in_table) begin
      next_s.table_q[paddr[4:2]] = bsad_aspect_type'(pwdata[`BSAD_ASP_W-1:0]);
    end
    // Staged only; the lamps see it at the next command
    if (wr & (paddr == `BSAD_OFF_BRIGHT)) begin
      next_s.stage_red = pwdata[7:0];
      next_s.stage_green = pwdata[15:8];
    end

    // Jumper caught once after reset release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.common_anode = common_anode_select;
    end

    // PWM period is the sum of both duties
    if (pwm_inc >= pwm_sum) begin
      next_s.pwm = 9'h000;
    end else begin
      next_s.pwm = pwm_inc;
    end

    case (s.st)
      BSAD_PRE: begin
        if (s.tmr == 23'(FLICKER_CYCLES - 1)) begin
          next_s.tmr = 23'h00_0000;
          next_s.st = BSAD_SHOW;
        end else begin
          next_s.tmr = s.tmr + 23'h00_0001;
        end
      end
      BSAD_SHOW: begin
        next_s.tmr = 23'h00_0000;
      end
      BSAD_DARK: begin
        next_s.tmr = 23'h00_0000;
      end
      default: begin
        next_s.st = BSAD_DARK;
        next_s.tmr = 23'h00_0000;
      end
    endcase

    if (cmd_hit) begin
      next_s.aspect = cmd_aspect;
      next_s.duty_red = s.stage_red;
      next_s.duty_green = s.stage_green;
      next_s.pwm = 9'h000;
      next_s.tmr = 23'h00_0000;
      if (s.table_q[cmd_aspect].prelight_effect) begin
        next_s.st = BSAD_PRE;
      end else begin
        next_s.st = BSAD_SHOW;
      end
    end

    // All-none entries give an empty mask, so every output rests at the common_anode level (low, or high in common-anode mode)
    next_s.drive = lit ^ {4{s.common_anode}};
  end

  // ==========================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= BSAD_DARK;
      s.stage_red <= `BSAD_DUTY_RST;
      s.stage_green <= `BSAD_DUTY_RST;
      s.duty_red <= `BSAD_DUTY_RST;
      s.duty_green <= `BSAD_DUTY_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign head_out_first = s.drive[0];
  assign head_out_second = s.drive[1];
  assign head_out_third = s.drive[2];
  assign head_out_fourth = s.drive[3];

endmodule : bsad_top
`default_nettype wire

// ### tb/bsad_checker_assertions.sv
// Port checker for the aspect driver.
// Assumes bsad_top ports; bound after the module.
`timescale 1ns/1ns
`default_nettype none
module bsad_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic common_anode_select,
  input wire logic head_out_first,
  input wire logic head_out_second,
  input wire logic head_out_third,
  input wire logic head_out_fourth
);
  // ==========
  // Bus timing, refusals and reset level
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence done_s;
    psel && penable && pready;
  endsequence
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  wait_state_a: assert property (setup_s |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  bad_addr_a: assert property (done_s ##0 (paddr > 8'h28) |-> pslverr)
    else $error("unmapped access accepted");
  status_wr_a: assert property (done_s ##0 (pwrite && paddr == 8'h28) |-> pslverr)
    else $error("status write accepted");
  good_addr_a: assert property (done_s ##0 (!pwrite && paddr <= 8'h28 && paddr[1:0] == 2'b00)
    |-> !pslverr)
    else $error("mapped read refused");
  dark_reset_a: assert property ($rose(presetn) |-> ##2
    {head_out_first, head_out_second, head_out_third, head_out_fourth}
    == {4{common_anode_select}}) else $error("head not dark after reset");
endmodule : bsad_checker
bind bsad_top bsad_checker bsad_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .common_anode_select(common_anode_select),
  .head_out_first(head_out_first), .head_out_second(head_out_second),
  .head_out_third(head_out_third), .head_out_fourth(head_out_fourth));
`default_nettype wire

// ### tb/bsad_led_model.sv
// Bi-polar lamp model on one output pair.
// Assumes common cathode wiring, first pin on the red die.
`timescale 1ns/1ns
`default_nettype none
module bsad_led_model (
  input wire logic drive_a,
  input wire logic drive_b,
  output logic red,
  output logic green
);
  // ==========
  // Equal levels leave both dies dark
  assign red = drive_a & ~drive_b;
  assign green = ~drive_a & drive_b;
endmodule : bsad_led_model
`default_nettype wire

// ### tb/tb_top.sv
// Bench for the aspect driver: APB tasks and lamp counts.
// Assumes bsad_top answers after one wait state.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t value %h", $time, a); end end
module tb_top;
  // ==========
  // Signals and instances
  localparam int FLK = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic common_anode_select = 0, pready, pslverr, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  wire logic [3:0] heads;
  wire logic red, green, red2, green2;
  int fail_count = 0, n_tests = 0, r, g, r2, g2;
  logic [31:0] tbl [5] = '{32'h1, 32'h6448, 32'h2, 32'h0, 32'h3};
  logic [2:0] cv [4] = '{3'h0, 3'h4, 3'h2, 3'h5};
  logic [3:0] ev [4] = '{4'h8, 4'h4, 4'h2, 4'h0};
  always #10 pclk = ~pclk;
  bsad_top #(.FLICKER_CYCLES(FLK)) bsad_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .common_anode_select(common_anode_select),
    .head_out_first(heads[3]), .head_out_second(heads[2]),
    .head_out_third(heads[1]), .head_out_fourth(heads[0]));
  bsad_led_model bsad_led_model_i (.drive_a(heads[3]), .drive_b(heads[2]),
    .red(red), .green(green));
  bsad_led_model bsad_led_model_far_i (.drive_a(heads[1]), .drive_b(heads[0]),
    .red(red2), .green(green2));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      fail_count++;
      end_sim();
    end
  endtask : apb
  task automatic cmd(input logic [2:0] c);
    apb(1'b1, 8'h20, {29'h0, c});
    @(posedge pclk);
    #1;
  endtask : cmd
  // Full pwm period so the count is exact whatever the phase
  task automatic cnt;
    repeat (FLK + 4) @(posedge pclk);
    r = 0;
    g = 0;
    r2 = 0;
    g2 = 0;
    repeat (256) begin
      @(posedge pclk);
      r += red;
      g += green;
      r2 += red2;
      g2 += green2;
    end
  endtask : cnt
  task automatic rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
  endtask : rst
  // ==========
  // Scenarios
  initial begin
    rst();
    `CHK(heads, 4'h0)
    apb(1'b0, 8'h28, 32'h0);
    `CHK(rd, 32'h8)
    for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), tbl[i]);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h6448)
    for (int i = 0; i < 4; i++) begin
      cmd(cv[i]);
      `CHK(heads, ev[i])
    end
    // Prelight aspect: lamp_b alone through the flicker, then the c/d pair toggles
    cmd(3'h1);
    `CHK(heads, 4'h8)
    repeat (FLK - 1) @(posedge pclk);
    #1;
    `CHK(heads, 4'h8)
    cnt();
    `CHK(r, 128)
    `CHK(g, 128)
    apb(1'b1, 8'h24, 32'h0000_c040);
    apb(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'h8080_c040)
    cmd(3'h1);
    cnt();
    `CHK(r, 64)
    `CHK(g, 192)
    // Pair flag on the far pair, no prelight
    apb(1'b1, 8'h18, 32'h0000_1023);
    cmd(3'h6);
    cnt();
    `CHK(r2, 64)
    `CHK(g2, 192)
    `CHK(r + g, 0)
    apb(1'b0, 8'h2c, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b1, 8'h28, 32'h0);
    `CHK(er, 1'b1)
    cmd(3'h5);
    @(posedge pclk);
    common_anode_select <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    `CHK(heads, 4'h0)
    rst();
    `CHK(heads, 4'hf)
    apb(1'b1, 8'h00, 32'h1);
    cmd(3'h0);
    `CHK(heads, 4'h7)
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
